/* verilog/frs_pkg.sv */
/*
 * frs_pkg: timing constants, state codes and the frame bit type for the
 * fast role swap and baseband transmit block.
 * Assumes a 100 MHz core clock.
 */
`default_nettype none
package frs_pkg;
   localparam int CLK_PERIOD_NS   = 10;
   // nominal unit interval, in ns
   localparam int UI_NS           = 3330;
   localparam int HALF_UI_CYC     = (UI_NS / 2) / CLK_PERIOD_NS;
   localparam int PREAMBLE_BITS   = 64;
   // least hold-low time after the last falling edge, in ns
   localparam int HOLD_LOW_NS     = 1000;
   localparam int HOLD_LOW_CYC    = (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest time to release the line after the frame, in UI
   localparam int END_DRIVE_UI    = 2;
   localparam int END_DRIVE_CYC   = (END_DRIVE_UI * UI_NS) / CLK_PERIOD_NS;
   // swap-request pulse window, in us
   localparam int FRS_TX_MIN_US   = 60;
   localparam int FRS_TX_MAX_US   = 120;
   localparam int FRS_TX_MIN_CYC  = (FRS_TX_MIN_US * 1000) / CLK_PERIOD_NS;
   localparam int FRS_TX_MAX_CYC  = (FRS_TX_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int FRS_TX_DEF_CYC  = (FRS_TX_MIN_CYC + FRS_TX_MAX_CYC) / 2;
   // swap-request detection window, in us
   localparam int FRS_RX_MIN_US   = 30;
   localparam int FRS_RX_MAX_US   = 50;
   localparam int FRS_RX_CYC      = ((FRS_RX_MIN_US + FRS_RX_MAX_US) * 500) / CLK_PERIOD_NS;
   // bist carrier duration window, in ms
   localparam int BIST_MIN_MS     = 30;
   localparam int BIST_MAX_MS     = 60;
   localparam int BIST_DEF_CYC    = ((BIST_MIN_MS + BIST_MAX_MS) * 500000) / CLK_PERIOD_NS;
   // longest latency from transmit command to preamble, in us
   localparam int TX_LAT_MAX_US   = 195;
   localparam int CNT_W           = 23;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_PRE  = 6'h02,
      ST_DATA = 6'h04,
      ST_HOLD = 6'h08,
      ST_BIST = 6'h10,
      ST_FRS  = 6'h20
   } frs_state_e;

   typedef struct packed {
      logic bit_val;
      logic last;
   } frs_txbit_s;
endpackage : frs_pkg
`default_nettype wire

/* verilog/frs_ui_tick.sv */
/*
 * frs_ui_tick: half unit interval enable divider.
 * Assumes run is a same-domain level; the count restarts while run is low.
 */
`timescale 1ns/1ps
`default_nettype none
module frs_ui_tick
   import frs_pkg::*;
(
   input  wire logic core_clk,  // core clock
   input  wire logic rst_b,     // async reset, active low
   input  wire logic run,       // enable divider
   output var  logic tick       // one-cycle pulse each half ui
);
   logic [7:0] cnt_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (!run) begin
         // preload so the first half ui also covers the cycle the driver turned on
         cnt_q <= 8'h01;
         tick  <= 1'b0;
      end else if (cnt_q == 8'(HALF_UI_CYC - 1)) begin
         cnt_q <= 8'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick  <= 1'b0;
      end
   end
endmodule : frs_ui_tick
`default_nettype wire

/* verilog/frs_pd_tx.sv */
/*
 * frs_pd_tx: fast role swap signalling and baseband bmc transmitter.
 * Assumes command inputs are single-cycle pulses on core_clk and that the
 * cc comparator input comes from the analog pin (synchronised here).
 */
`timescale 1ns/1ps
`default_nettype none
module frs_pd_tx
   import frs_pkg::*;
#(
   parameter int FRS_TX_CYC = FRS_TX_DEF_CYC,   // swap pulse length
   parameter int BIST_CYC   = BIST_DEF_CYC      // bist carrier length
)(
   input  wire logic       core_clk,                    // core clock
   input  wire logic       rst_b,                       // async reset, active low
   input  wire logic       role_source,                 // port is power source
   input  wire logic       explicit_contract,           // contract in place
   input  wire logic       frs_cmd,                     // start swap pulse
   input  wire logic       frs_armed,                   // sink ready for swap
   input  wire logic       frs_det_clear,               // clear detect flag
   input  wire logic       sink_tx_ng_cmd,              // withdraw sinktx ok
   input  wire logic       cc_low_pin,                  // cc below swap threshold
   input  wire logic       tx_start,                    // transmit command
   input  wire logic       bist_start,                  // bist carrier command
   input  wire frs_txbit_s tx_bit,                      // next frame bit
   input  wire logic       tx_bit_valid,                // tx_bit valid
   output var  logic       tx_bit_ready,                // tx_bit taken
   output var  logic       tx_busy,                     // transmitter active
   output var  logic       cc_bmc_out,                  // bmc line level
   output var  logic       cc_bmc_oe,                   // bmc driver enable
   output var  logic       cc_frs_pulldown,             // strong pull to ground
   output var  logic       protocol_layer_reset_pulse,  // discard queued msgs
   output var  logic       sink_tx_permitted_pullup,    // 3.0 a rp advertised
   output var  logic       frs_detected                 // swap request seen
);
   frs_state_e       st_q;
   logic [CNT_W-1:0] cnt_q;
   logic [6:0]       pre_q;
   logic             half_q;
   logic             cur_q;
   logic             cur_last_q;
   logic             nxt_q;
   logic             nxt_last_q;
   logic             nxt_full_q;
   logic             cc_low_s1_q;
   logic             cc_low_s2_q;
   logic [11:0]      det_cnt_q;
   logic             tick;
   logic             frs_go;
   logic             tx_go;
   logic             bist_go;
   logic             accept;
   logic             bound;
   logic             load;
   logic             frs_end;

   frs_ui_tick u_tick (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .run      (st_q == ST_PRE || st_q == ST_DATA || st_q == ST_BIST),
      .tick     (tick)
   );

   assign frs_go  = frs_cmd && explicit_contract && role_source && st_q != ST_FRS;
   assign tx_go   = tx_start && st_q == ST_IDLE && !(role_source && sink_tx_permitted_pullup);
   assign bist_go = bist_start && st_q == ST_IDLE && !tx_start;
   assign accept  = tx_bit_valid && tx_bit_ready;
   assign bound   = tick && half_q;
   // the last preamble boundary already loads the first frame bit
   assign load    = bound && (st_q == ST_DATA || (st_q == ST_PRE &&
                    pre_q == 7'(PREAMBLE_BITS - 1))) && !cur_last_q && nxt_full_q;
   assign frs_end = st_q == ST_FRS && cnt_q == CNT_W'(FRS_TX_CYC - 1);

   // main sequencer; the swap request overrides anything in flight
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
      end else if (frs_go) begin
         st_q  <= ST_FRS;
         cnt_q <= '0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               cnt_q <= '0;
               if (tx_go) st_q <= ST_PRE;
               else if (bist_go) st_q <= ST_BIST;
            end
            ST_PRE: begin
               if (bound && pre_q == 7'(PREAMBLE_BITS - 1)) st_q <= ST_DATA;
            end
            ST_DATA: begin
               if (bound && !load) begin
                  st_q  <= ST_HOLD;
                  cnt_q <= '0;
               end
            end
            ST_BIST: begin
               if (cnt_q == CNT_W'(BIST_CYC - 1)) begin
                  st_q  <= ST_HOLD;
                  cnt_q <= '0;
               end else cnt_q <= cnt_q + 1'b1;
            end
            ST_HOLD: begin
               if (cnt_q == CNT_W'(HOLD_LOW_CYC - 1)) st_q <= ST_IDLE;
               else cnt_q <= cnt_q + 1'b1;
            end
            ST_FRS: begin
               if (frs_end) st_q <= ST_IDLE;
               else cnt_q <= cnt_q + 1'b1;
            end
            default: begin
               st_q  <= ST_IDLE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // bmc bit sequencing: preamble count, half index and current bit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_q      <= 7'h00;
         half_q     <= 1'b0;
         cur_q      <= 1'b0;
         cur_last_q <= 1'b0;
      end else if (tx_go || bist_go) begin
         pre_q      <= 7'h00;
         half_q     <= 1'b0;
         cur_q      <= 1'b0;
         cur_last_q <= 1'b0;
      end else if (tick) begin
         half_q <= !half_q;
         if (half_q) begin
            pre_q      <= pre_q + 7'h01;
            cur_q      <= load ? nxt_q : !cur_q;
            cur_last_q <= load && nxt_last_q;
         end
      end
   end

   // one staged frame bit ahead of the encoder
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         nxt_q        <= 1'b0;
         nxt_last_q   <= 1'b0;
         nxt_full_q   <= 1'b0;
         tx_bit_ready <= 1'b0;
      end else begin
         if (accept) begin
            nxt_q      <= tx_bit.bit_val;
            nxt_last_q <= tx_bit.last;
            nxt_full_q <= 1'b1;
         end else if (load || st_q == ST_IDLE || st_q == ST_FRS) begin
            nxt_full_q <= 1'b0;
         end
         tx_bit_ready <= (st_q == ST_PRE || st_q == ST_DATA) && !frs_go
                         && !accept && !(nxt_full_q && !load);
      end
   end

   // line drive: transition at every bit start, mid-bit for a one
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cc_bmc_out <= 1'b0;
         cc_bmc_oe  <= 1'b0;
         tx_busy    <= 1'b0;
      end else if (frs_go) begin
         cc_bmc_out <= 1'b0;
         cc_bmc_oe  <= 1'b0;
         tx_busy    <= 1'b0;
      end else if (tx_go || bist_go) begin
         cc_bmc_out <= 1'b1;
         cc_bmc_oe  <= 1'b1;
         tx_busy    <= 1'b1;
      end else if (st_q == ST_HOLD) begin
         cc_bmc_out <= 1'b0;
         if (cnt_q == CNT_W'(HOLD_LOW_CYC - 1)) begin
            cc_bmc_oe <= 1'b0;
            tx_busy   <= 1'b0;
         end
      end else if ((st_q == ST_DATA && bound && !load) ||
                   (st_q == ST_BIST && cnt_q == CNT_W'(BIST_CYC - 1))) begin
         cc_bmc_out <= 1'b0;
      end else if (tick && (half_q || cur_q)) begin
         cc_bmc_out <= !cc_bmc_out;
      end
   end

   // swap request pulse, protocol reset and sinktx advertisement
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cc_frs_pulldown            <= 1'b0;
         protocol_layer_reset_pulse <= 1'b0;
         sink_tx_permitted_pullup   <= 1'b0;
      end else begin
         protocol_layer_reset_pulse <= frs_go;
         if (frs_go) cc_frs_pulldown <= 1'b1;
         else if (frs_end) cc_frs_pulldown <= 1'b0;
         if (frs_end) sink_tx_permitted_pullup <= 1'b1;
         else if (sink_tx_ng_cmd) sink_tx_permitted_pullup <= 1'b0;
      end
   end

   // sink side: cc held low while armed, including a detach through rd
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cc_low_s1_q  <= 1'b0;
         cc_low_s2_q  <= 1'b0;
         det_cnt_q    <= 12'h000;
         frs_detected <= 1'b0;
      end else begin
         cc_low_s1_q <= cc_low_pin;
         cc_low_s2_q <= cc_low_s1_q;
         if (!(cc_low_s2_q && frs_armed && !role_source)) det_cnt_q <= 12'h000;
         else if (det_cnt_q != 12'(FRS_RX_CYC)) det_cnt_q <= det_cnt_q + 12'h001;
         if (det_cnt_q == 12'(FRS_RX_CYC - 1) && cc_low_s2_q && frs_armed && !role_source)
            frs_detected <= 1'b1;
         else if (frs_det_clear) frs_detected <= 1'b0;
      end
   end

   localparam int ENDW = END_DRIVE_CYC;
   logic [13:0] pd_len_q;
   logic [7:0]  low_len_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pd_len_q  <= 14'h0000;
         low_len_q <= 8'h00;
      end else begin
         pd_len_q  <= cc_frs_pulldown ? pd_len_q + 14'h0001 : 14'h0000;
         low_len_q <= (cc_bmc_oe && !cc_bmc_out && low_len_q != 8'hff) ?
                      low_len_q + 8'h01 : 8'h00;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_frs_contract: assert property ($rose(cc_frs_pulldown) |-> $past(explicit_contract) && $past(role_source))
      else $error("swap pulse without contract");
   chk_frs_reset: assert property ($rose(cc_frs_pulldown) |-> protocol_layer_reset_pulse ##1 !protocol_layer_reset_pulse)
      else $error("protocol reset not pulsed");
   chk_frs_override: assert property (cc_frs_pulldown |-> !cc_bmc_oe && !tx_busy)
      else $error("bmc drive during swap pulse");
   chk_frs_width: assert property ($fell(cc_frs_pulldown) |-> pd_len_q >= 14'(FRS_TX_MIN_CYC) && pd_len_q <= 14'(FRS_TX_MAX_CYC))
      else $error("swap pulse length out of range");
   chk_sinktx_after: assert property ($fell(cc_frs_pulldown) |-> sink_tx_permitted_pullup)
      else $error("sinktx not advertised after swap");
   chk_hold_low: assert property ($fell(cc_bmc_oe) && !cc_frs_pulldown |-> low_len_q >= 8'(HOLD_LOW_CYC))
      else $error("line released too early");
   chk_end_drive: assert property ($rose(st_q == ST_HOLD) |-> ##[1:ENDW] !cc_bmc_oe)
      else $error("line not released in time");
   chk_start_drive: assert property (tx_go |=> cc_bmc_oe && cc_bmc_out ##1 cc_bmc_oe)
      else $error("drive did not start with preamble");
   chk_frs_detect: assert property ($rose(frs_detected) |-> $past(cc_low_s2_q) && $past(frs_armed))
      else $error("swap detect without cc low");

   cov_frs_pulse:  cover property ($fell(cc_frs_pulldown));
   cov_tx_frame:   cover property ($fell(cc_bmc_oe) && !cc_frs_pulldown);
   cov_frs_cut:    cover property (tx_busy && frs_go);
   cov_frs_detect: cover property ($rose(frs_detected));
endmodule : frs_pd_tx
`default_nettype wire

/* bench/frs_port_partner.sv */
/*
 * frs_port_partner: far end of the cc line for the swap tests.
 * Assumes the core clock domain; it feeds the comparator input of the block.
 */
`timescale 1ns/1ps
`default_nettype none
module frs_port_partner (
   input  wire logic        core_clk,         // core clock
   input  wire logic        rst_b,            // async reset, active low
   input  wire logic        cc_frs_pulldown,  // device strong pull
   input  wire logic        detached,         // cable gone, own pull-down holds cc
   input  wire logic        frs_go,           // start partner swap pulse
   input  wire logic [15:0] frs_len,          // partner pulse length, cycles
   output wire logic        cc_low_pin,       // cc below swap threshold
   output var  logic [15:0] low_cnt_q         // length of last device pulse
);
   logic [15:0] left_q;
   logic        pd_q;

   // pulse is only started by the bench while this side is source with a contract
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) left_q <= 16'h0;
      else if (frs_go) left_q <= frs_len;
      else if (left_q != 16'h0) left_q <= left_q - 16'h1;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pd_q      <= 1'b0;
         low_cnt_q <= 16'h0;
      end else begin
         pd_q <= cc_frs_pulldown;
         if (cc_frs_pulldown) low_cnt_q <= pd_q ? low_cnt_q + 16'h1 : 16'h1;
      end
   end

   // any pull to ground wins on the shared wire
   assign cc_low_pin = (left_q != 16'h0) | detached | cc_frs_pulldown;
endmodule : frs_port_partner
`default_nettype wire

/* bench/tb_fast_role_swap_pd_tx.sv */
/*
 * tb_fast_role_swap_pd_tx: self-checking bench for frs_pd_tx.
 * Assumes the partner model on the cc side; bist length shortened.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
`define WAITW(c, n) begin k = 0; while ((c) && k < (n)) begin \
   @(posedge core_clk); #1; k++; end if (k >= (n)) tmo(); end
// one-cycle command, returns just after the taking edge
`define PULSE(s) begin @(posedge core_clk); s <= 1'b1; \
   @(posedge core_clk); s <= 1'b0; #1; end
module tb_fast_role_swap_pd_tx
   import frs_pkg::*;
;
   localparam int FRS_CYC = 9000;
   localparam int BIST_C  = 2000;
   logic        core_clk = 1'b0, rst_b = 1'b0;
   logic        role_source = 1'b0, explicit_contract = 1'b0, frs_cmd = 1'b0;
   logic        frs_armed = 1'b0, frs_det_clear = 1'b0, sink_tx_ng_cmd = 1'b0;
   logic        tx_start = 1'b0, bist_start = 1'b0, tx_bit_valid = 1'b0;
   logic        detached = 1'b0, frs_go = 1'b0;
   logic [15:0] frs_len = 16'h0;
   frs_txbit_s  tx_bit = '0;
   logic        tx_bit_ready, tx_busy, cc_bmc_out, cc_bmc_oe, cc_frs_pulldown;
   logic        protocol_layer_reset_pulse, sink_tx_permitted_pullup, frs_detected;
   logic        cc_low_pin, p;
   logic [15:0] low_cnt;
   int          mismatches = 0, cmp_count = 0, k, h;

   always #5 core_clk = ~core_clk;

   frs_pd_tx #(.FRS_TX_CYC(FRS_CYC), .BIST_CYC(BIST_C)) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .role_source(role_source),
      .explicit_contract(explicit_contract), .frs_cmd(frs_cmd), .frs_armed(frs_armed),
      .frs_det_clear(frs_det_clear), .sink_tx_ng_cmd(sink_tx_ng_cmd),
      .cc_low_pin(cc_low_pin), .tx_start(tx_start), .bist_start(bist_start),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready),
      .tx_busy(tx_busy), .cc_bmc_out(cc_bmc_out), .cc_bmc_oe(cc_bmc_oe),
      .cc_frs_pulldown(cc_frs_pulldown),
      .protocol_layer_reset_pulse(protocol_layer_reset_pulse),
      .sink_tx_permitted_pullup(sink_tx_permitted_pullup), .frs_detected(frs_detected));

   frs_port_partner i_partner (
      .core_clk(core_clk), .rst_b(rst_b), .cc_frs_pulldown(cc_frs_pulldown),
      .detached(detached), .frs_go(frs_go), .frs_len(frs_len),
      .cc_low_pin(cc_low_pin), .low_cnt_q(low_cnt));

   task give_verdict;
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   task tmo;
      mismatches++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, k, 0);
      give_verdict();
   endtask : tmo

   task t_refuse;
      role_source <= 1'b1;
      `PULSE(frs_cmd)
      `CHK(cc_frs_pulldown, 1'b0)
      `CHK(protocol_layer_reset_pulse, 1'b0)
   endtask : t_refuse

   task t_swap;
      explicit_contract <= 1'b1;
      `PULSE(frs_cmd)
      `CHK(cc_frs_pulldown, 1'b1)
      `CHK(protocol_layer_reset_pulse, 1'b1)
      @(posedge core_clk); #1;
      `CHK(protocol_layer_reset_pulse, 1'b0)
      `CHK(sink_tx_permitted_pullup, 1'b0)
      `WAITW(cc_frs_pulldown === 1'b1, 20000)
      `CHK(low_cnt, 16'(FRS_CYC))
      `CHK(sink_tx_permitted_pullup, 1'b1)
      `PULSE(tx_start)
      `CHK(tx_busy, 1'b0)
      `PULSE(sink_tx_ng_cmd)  // firmware then runs the swap messages and roles
      @(posedge core_clk); #1;
      `CHK(sink_tx_permitted_pullup, 1'b0)
   endtask : t_swap

   task t_tx;
      logic [7:0] fr;
      fr = 8'he2;
      `PULSE(tx_start)
      `CHK({cc_bmc_oe, cc_bmc_out, tx_busy}, 3'h7)
      `WAITW(cc_bmc_out === 1'b1, 1000)
      `CHK(k, 2 * HALF_UI_CYC)
      @(posedge core_clk);
      for (int b = 0; b < 4; b++) begin
         tx_bit <= frs_txbit_s'(fr[2*b +: 2]);
         tx_bit_valid <= 1'b1;
         k = 0;
         do begin @(posedge core_clk); k++; end while (tx_bit_ready !== 1'b1 && k < 30000);
         if (k >= 30000) tmo();
      end
      tx_bit_valid <= 1'b0;
      h = 0;
      k = 0;
      while (cc_bmc_oe === 1'b1 && k < 3000) begin
         p = cc_bmc_out;
         @(posedge core_clk); #1;
         k++;
         h = (cc_bmc_out !== p) ? 0 : h + 1;
      end
      if (k >= 3000) tmo();
      `CHK(p, 1'b0)
      `CHK(h >= HOLD_LOW_CYC, 1'b1)
      `CHK(h <= HALF_UI_CYC + END_DRIVE_CYC, 1'b1)
      `CHK(tx_busy, 1'b0)
   endtask : t_tx

   task t_abort;
      `PULSE(tx_start)
      repeat (500) @(posedge core_clk);
      `PULSE(frs_cmd)
      `CHK({cc_bmc_oe, tx_busy, tx_bit_ready, cc_frs_pulldown}, 4'h1)
      `CHK(protocol_layer_reset_pulse, 1'b1)
      `WAITW(cc_frs_pulldown === 1'b1, 20000)
      `PULSE(sink_tx_ng_cmd)
   endtask : t_abort

   task t_bist;
      `PULSE(bist_start)
      `WAITW(tx_busy === 1'b1, 5000)
      `CHK(k >= BIST_C && k <= BIST_C + HOLD_LOW_CYC + 4, 1'b1)
      `CHK(cc_bmc_oe, 1'b0)
   endtask : t_bist

   task t_detect;
      role_source <= 1'b0;
      frs_armed   <= 1'b1;  // firmware keeps auto discharge off here
      frs_len     <= 16'd2000;
      `PULSE(frs_go)
      repeat (2100) @(posedge core_clk); #1;
      `CHK(frs_detected, 1'b0)
      frs_len <= 16'd6000;
      `PULSE(frs_go)
      repeat (2990) @(posedge core_clk); #1;
      `CHK(frs_detected, 1'b0)
      repeat (2020) @(posedge core_clk); #1;
      `CHK(frs_detected, 1'b1)
      repeat (1100) @(posedge core_clk);
      `PULSE(frs_det_clear)
      @(posedge core_clk); #1;
      `CHK(frs_detected, 1'b0)
      detached <= 1'b1;
      repeat (5010) @(posedge core_clk); #1;
      `CHK(frs_detected, 1'b1)
      detached <= 1'b0;  // swap message then goes unanswered, firmware recovers
   endtask : t_detect

   initial begin
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      t_refuse();
      t_swap();
      t_tx();
      t_abort();
      t_bist();
      t_detect();
      give_verdict();
   end
endmodule : tb_fast_role_swap_pd_tx
`default_nettype wire
